// File: hw/sensor_config_serial_regs.sv
`timescale 1ns/100ps
`default_nettype none

`include "sensor_regs_defs.svh"

// Functional notes
// [RULE1] mode 0: convert only pointer-selected quantity
// [RULE2] mode 1: temperature then humidity, back to back
// [RULE3] bit 11 shows low supply, read-only
// [RULE4] bit 10: 0 gives 14-bit, 1 gives 11-bit temperature
// [RULE5] bits 9:8 pick 14, 11 or 8-bit humidity
// [RULE6] fixed per-unit serial identifier, read-only
// [RULE7] pointer 0xFB reads identifier bits 40 to 25
// [RULE8] pointer 0xFC reads identifier bits 24 to 9
// [RULE9] bit 13 switches the heater
// [RULE10] host writes zero to reserved bits
// [RULE11] host sets pointer by write before reading
// [RULE12] bit 15 soft reset, self-clearing
module sensor_config_serial_regs #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h40,
  // arbitrary per-unit value, replaced per unit at build time
  parameter logic [40:0] UNIT_ID = 41'h0_1234_5678_9a
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic supplyLowIn,
  input wire logic convDone,
  output logic convStart,
  output logic convHumidity,
  output logic [3:0] convBits,
  output logic heaterOn,
  output logic softResetPulse
);

  // ==================================================
  // pin synchronisation
  logic sclSync; // clock line after two flops
  logic sdaSync; // data line after two flops
  logic supplyLowSync; // supply comparator after two flops
  logic sclPrev_reg; // last sampled clock line
  logic sdaPrev_reg; // last sampled data line

  sync_two_flop #(.RESET_VALUE(1'b1)) sclSyncInst (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(sclIn),
    .syncOut(sclSync)
  );

  sync_two_flop #(.RESET_VALUE(1'b1)) sdaSyncInst (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(sdaIn),
    .syncOut(sdaSync)
  );

  sync_two_flop #(.RESET_VALUE(1'b0)) supplySyncInst (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(supplyLowIn),
    .syncOut(supplyLowSync)
  );

  // ==================================================
  // state
  sensor_regs_pkg::link_state_t linkState_reg; // serial phase
  sensor_regs_pkg::meas_state_t measState_reg; // sequencer phase
  logic [3:0] bitCount_reg; // bits moved in this byte
  logic [7:0] rxShift_reg; // incoming byte
  logic [1:0] byteIndex_reg; // bytes received in a write
  logic readMode_reg; // direction bit of the address byte
  logic hostNack_reg; // host declined further bytes
  logic [7:0] pointer_reg; // register pointer
  logic [7:0] cfgUpper_reg; // held first data byte
  logic [15:0] txWord_reg; // word being read out
  logic txUpper_reg; // upper byte of word in flight
  logic sdaOe_reg; // pulling the data line low
  logic heater_reg; // heater field
  logic seqMode_reg; // acquisition mode field
  logic tempRes_reg; // temperature resolution field
  logic [1:0] humRes_reg; // humidity resolution field
  logic seqBoth_reg; // current measurement does both
  logic convStart_reg; // start strobe to converter
  logic convHumidity_reg; // converter quantity select
  logic [3:0] convBits_reg; // converter width select
  logic softReset_reg; // soft reset strobe

  // ==================================================
  // line events and decode
  wire sclRise = sclSync & ~sclPrev_reg;
  wire sclFall = ~sclSync & sclPrev_reg;
  wire startSeen = sclSync & sclPrev_reg & sdaPrev_reg & ~sdaSync;
  wire stopSeen = sclSync & sclPrev_reg & ~sdaPrev_reg & sdaSync;
  wire byteFull = (bitCount_reg == `BITS_PER_BYTE);
  wire addrMatch = (rxShift_reg[7:1] == DEVICE_ADDRESS);
  wire ptrByte = (byteIndex_reg == `BYTE_IDX_PTR);
  wire cfgWrite = (byteIndex_reg == `BYTE_IDX_LSB) && (pointer_reg == `PTR_CONFIG);
  wire softResetReq = cfgWrite & cfgUpper_reg[`CFG_SOFT_RESET - 8]; // RULE12
  wire measSelect = (rxShift_reg == `PTR_TEMPERATURE) || (rxShift_reg == `PTR_HUMIDITY);
  wire measTrigger = (linkState_reg == sensor_regs_pkg::LINK_WRITE) & sclFall & byteFull
    & ptrByte & measSelect & (measState_reg == sensor_regs_pkg::MEAS_IDLE);
  wire [7:0] txByte = txUpper_reg ? txWord_reg[15:8] : txWord_reg[7:0];
  wire [2:0] txIndex = 3'(3'h7 - bitCount_reg[2:0]);
  wire txBit = txByte[txIndex];
  wire nextUpperBit = txUpper_reg ? txWord_reg[7] : txWord_reg[15];

  // configuration image; reserved bits and soft reset read as zero
  wire [15:0] cfgImage = {2'h0, heater_reg, seqMode_reg, supplyLowSync, // RULE3
    tempRes_reg, humRes_reg, 8'h00};

  // read mux by pointer; unmapped and excluded registers read zero
  wire [15:0] readWord =
    (pointer_reg == `PTR_CONFIG) ? cfgImage :
    (pointer_reg == `PTR_ID_UPPER) ? UNIT_ID[40:25] : // RULE6 RULE7
    (pointer_reg == `PTR_ID_MIDDLE) ? UNIT_ID[24:9] : // RULE8
    16'h0000;

  // conversion widths from the fields
  wire [3:0] tempBits = tempRes_reg ? `CONV_BITS_11 : `CONV_BITS_14; // RULE4
  wire [3:0] humBits = (humRes_reg == `HUM_RES_14) ? `CONV_BITS_14 : // RULE5
    (humRes_reg == `HUM_RES_11) ? `CONV_BITS_11 : `CONV_BITS_8;

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_reg;
  assign heaterOn = heater_reg; // RULE9
  assign convStart = convStart_reg;
  assign convHumidity = convHumidity_reg;
  assign convBits = convBits_reg;
  assign softResetPulse = softReset_reg;

  // ==================================================
  // line history
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end
    else
    begin
      sclPrev_reg <= sclSync;
      sdaPrev_reg <= sdaSync;
    end
  end

  // ==================================================
  // serial engine: sample on rising clock, drive on falling clock
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      linkState_reg <= sensor_regs_pkg::LINK_IDLE;
      bitCount_reg <= 4'h0;
      rxShift_reg <= 8'h00;
      byteIndex_reg <= `BYTE_IDX_PTR;
      readMode_reg <= 1'b0;
      hostNack_reg <= 1'b0;
      pointer_reg <= `PTR_RESET;
      cfgUpper_reg <= 8'h00;
      txWord_reg <= 16'h0000;
      txUpper_reg <= 1'b1;
      sdaOe_reg <= 1'b0;
    end
    else if (startSeen)
    begin
      // start or repeated start
      linkState_reg <= sensor_regs_pkg::LINK_ADDR;
      bitCount_reg <= 4'h0;
      byteIndex_reg <= `BYTE_IDX_PTR;
      sdaOe_reg <= 1'b0;
    end
    else if (stopSeen)
    begin
      linkState_reg <= sensor_regs_pkg::LINK_IDLE;
      sdaOe_reg <= 1'b0;
    end
    else if (sclRise)
    begin
      // shift in address or data, or catch the host acknowledge
      if (linkState_reg == sensor_regs_pkg::LINK_ACK_READ)
      begin
        hostNack_reg <= sdaSync;
      end
      else if (linkState_reg != sensor_regs_pkg::LINK_IDLE)
      begin
        rxShift_reg <= {rxShift_reg[6:0], sdaSync};
        bitCount_reg <= bitCount_reg + 4'h1;
      end
    end
    else if (sclFall)
    begin
      unique case (linkState_reg)
        sensor_regs_pkg::LINK_IDLE:
        begin
          sdaOe_reg <= 1'b0;
        end
        sensor_regs_pkg::LINK_ADDR:
        begin
          // acknowledge own address only
          if (byteFull)
          begin
            sdaOe_reg <= addrMatch;
            readMode_reg <= rxShift_reg[0];
            linkState_reg <= addrMatch ? sensor_regs_pkg::LINK_ACK_ADDR
              : sensor_regs_pkg::LINK_IDLE;
          end
        end
        sensor_regs_pkg::LINK_ACK_ADDR:
        begin
          bitCount_reg <= 4'h0;
          if (readMode_reg)
          begin
            // read uses the pointer left by the last write
            txWord_reg <= readWord; // RULE11
            txUpper_reg <= 1'b1;
            sdaOe_reg <= ~readWord[15];
            linkState_reg <= sensor_regs_pkg::LINK_READ;
          end
          else
          begin
            sdaOe_reg <= 1'b0;
            linkState_reg <= sensor_regs_pkg::LINK_WRITE;
          end
        end
        sensor_regs_pkg::LINK_WRITE:
        begin
          if (byteFull)
          begin
            // first byte loads the pointer, then upper and lower data
            sdaOe_reg <= 1'b1;
            linkState_reg <= sensor_regs_pkg::LINK_ACK_WRITE;
            if (ptrByte)
            begin
              pointer_reg <= rxShift_reg; // RULE11
            end
            if (byteIndex_reg == `BYTE_IDX_MSB)
            begin
              cfgUpper_reg <= rxShift_reg;
            end
            if (byteIndex_reg != `BYTE_IDX_MAX)
            begin
              byteIndex_reg <= byteIndex_reg + 2'h1;
            end
          end
        end
        sensor_regs_pkg::LINK_ACK_WRITE:
        begin
          sdaOe_reg <= 1'b0;
          bitCount_reg <= 4'h0;
          linkState_reg <= sensor_regs_pkg::LINK_WRITE;
        end
        sensor_regs_pkg::LINK_READ:
        begin
          // release for host acknowledge after eight bits
          if (byteFull)
          begin
            sdaOe_reg <= 1'b0;
            linkState_reg <= sensor_regs_pkg::LINK_ACK_READ;
          end
          else
          begin
            sdaOe_reg <= ~txBit;
          end
        end
        sensor_regs_pkg::LINK_ACK_READ:
        begin
          bitCount_reg <= 4'h0;
          if (hostNack_reg)
          begin
            sdaOe_reg <= 1'b0;
            linkState_reg <= sensor_regs_pkg::LINK_IDLE;
          end
          else
          begin
            // alternate bytes of the same word
            txUpper_reg <= ~txUpper_reg;
            sdaOe_reg <= ~nextUpperBit;
            linkState_reg <= sensor_regs_pkg::LINK_READ;
          end
        end
        default:
        begin
          sdaOe_reg <= 1'b0;
          linkState_reg <= sensor_regs_pkg::LINK_IDLE;
        end
      endcase
    end
  end

  // ==================================================
  // configuration fields; reserved bits are dropped on write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      heater_reg <= `CFG_HEATER_RST;
      seqMode_reg <= `CFG_MODE_RST;
      tempRes_reg <= `CFG_TEMP_RES_RST;
      humRes_reg <= `CFG_HUM_RES_RST;
      softReset_reg <= 1'b0;
    end
    else
    begin
      softReset_reg <= 1'b0;
      if ((linkState_reg == sensor_regs_pkg::LINK_WRITE) & sclFall & byteFull & cfgWrite)
      begin
        if (softResetReq)
        begin
          // soft reset restores defaults; the bit is not stored
          heater_reg <= `CFG_HEATER_RST; // RULE12
          seqMode_reg <= `CFG_MODE_RST;
          tempRes_reg <= `CFG_TEMP_RES_RST;
          humRes_reg <= `CFG_HUM_RES_RST;
          softReset_reg <= 1'b1;
        end
        else
        begin
          heater_reg <= cfgUpper_reg[`CFG_HEATER - 8]; // RULE9
          seqMode_reg <= cfgUpper_reg[`CFG_MODE - 8];
          tempRes_reg <= cfgUpper_reg[`CFG_TEMP_RES - 8]; // RULE4
          humRes_reg <= cfgUpper_reg[`CFG_HUM_RES_HI - 8:`CFG_HUM_RES_LO - 8]; // RULE5
        end
      end
    end
  end

  // ==================================================
  // measurement sequencer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      measState_reg <= sensor_regs_pkg::MEAS_IDLE;
      seqBoth_reg <= 1'b0;
      convStart_reg <= 1'b0;
      convHumidity_reg <= 1'b0;
      convBits_reg <= `CONV_BITS_14;
    end
    else
    begin
      convStart_reg <= 1'b0;
      if (softReset_reg)
      begin
        // abandon any measurement in progress
        measState_reg <= sensor_regs_pkg::MEAS_IDLE;
      end
      else
      begin
        unique case (measState_reg)
          sensor_regs_pkg::MEAS_IDLE:
          begin
            if (measTrigger)
            begin
              convStart_reg <= 1'b1;
              seqBoth_reg <= seqMode_reg;
              if (seqMode_reg | (rxShift_reg == `PTR_TEMPERATURE))
              begin
                // temperature alone, or first of the pair
                convHumidity_reg <= 1'b0; // RULE1 RULE2
                convBits_reg <= tempBits;
                measState_reg <= sensor_regs_pkg::MEAS_TEMP;
              end
              else
              begin
                convHumidity_reg <= 1'b1; // RULE1
                convBits_reg <= humBits;
                measState_reg <= sensor_regs_pkg::MEAS_HUM;
              end
            end
          end
          sensor_regs_pkg::MEAS_TEMP:
          begin
            if (convDone & seqBoth_reg)
            begin
              // humidity follows temperature at once
              convStart_reg <= 1'b1; // RULE2
              convHumidity_reg <= 1'b1;
              convBits_reg <= humBits;
              measState_reg <= sensor_regs_pkg::MEAS_HUM;
            end
            else if (convDone)
            begin
              measState_reg <= sensor_regs_pkg::MEAS_IDLE;
            end
          end
          sensor_regs_pkg::MEAS_HUM:
          begin
            if (convDone)
            begin
              measState_reg <= sensor_regs_pkg::MEAS_IDLE;
            end
          end
          default:
          begin
            measState_reg <= sensor_regs_pkg::MEAS_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: hw/sensor_regs_defs.svh
`ifndef SENSOR_REGS_DEFS_SVH
`define SENSOR_REGS_DEFS_SVH

// ==================================================
// register pointer values
`define PTR_TEMPERATURE 8'h00
`define PTR_HUMIDITY 8'h01
`define PTR_CONFIG 8'h02
`define PTR_ID_UPPER 8'hfb
`define PTR_ID_MIDDLE 8'hfc
`define PTR_RESET 8'h00

// ==================================================
// configuration field positions
`define CFG_SOFT_RESET 15
`define CFG_HEATER 13
`define CFG_MODE 12
`define CFG_SUPPLY_LOW 11
`define CFG_TEMP_RES 10
`define CFG_HUM_RES_HI 9
`define CFG_HUM_RES_LO 8

// ==================================================
// configuration reset values
`define CFG_HEATER_RST 1'h0
`define CFG_MODE_RST 1'h0
`define CFG_TEMP_RES_RST 1'h0
`define CFG_HUM_RES_RST 2'h0

// ==================================================
// humidity resolution codes and conversion widths
`define HUM_RES_14 2'h0
`define HUM_RES_11 2'h1
`define CONV_BITS_14 4'he
`define CONV_BITS_11 4'hb
`define CONV_BITS_8 4'h8

// ==================================================
// serial engine counts
`define BITS_PER_BYTE 4'h8
`define BYTE_IDX_PTR 2'h0
`define BYTE_IDX_MSB 2'h1
`define BYTE_IDX_LSB 2'h2
`define BYTE_IDX_MAX 2'h3

`endif

// File: hw/sensor_regs_pkg.sv
package sensor_regs_pkg;

  // serial engine phases
  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ACK_ADDR,
    LINK_WRITE,
    LINK_ACK_WRITE,
    LINK_READ,
    LINK_ACK_READ
  } link_state_t;

  // measurement sequencer phases
  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_TEMP,
    MEAS_HUM
  } meas_state_t;

endpackage

// File: hw/sync_two_flop.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser; the first stage feeds only the second
module sync_two_flop #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);

  // first stage, read by nothing but the second stage
  logic meta_reg;

  // ==================================================
  // two flops in series
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RESET_VALUE;
      syncOut <= RESET_VALUE;
    end
    else
    begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// File: verif/sensor_config_serial_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// port checker for the sensor register block
module sensor_config_serial_regs_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic supplyLowIn,
  input wire logic convDone,
  input wire logic convStart,
  input wire logic convHumidity,
  input wire logic [3:0] convBits,
  input wire logic heaterOn,
  input wire logic softResetPulse
);
  logic pending_reg; // a conversion is outstanding
  // set on start, cleared by done or soft reset
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      pending_reg <= 1'b0;
    else
      pending_reg <= (pending_reg | convStart) & ~convDone & ~softResetPulse;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_start_single: assert property (convStart |=> !convStart)
    else $error("conversion start longer than one cycle");
  a_start_idle: assert property (convStart |-> !pending_reg)
    else $error("conversion started while one is outstanding");
  a_temp_width: assert property (convStart && !convHumidity |-> convBits inside {4'he, 4'hb})
    else $error("bad temperature width");
  a_hum_width: assert property (convStart && convHumidity |-> convBits inside {4'he, 4'hb, 4'h8})
    else $error("bad humidity width");
  a_temp_first: assert property (convStart && $past(convDone) |-> convHumidity)
    else $error("second conversion is not humidity");
  a_pulse_single: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset pulse too long");
  a_reset_heater: assert property (softResetPulse |=> !heaterOn [*3])
    else $error("heater kept after soft reset");
  a_reset_abort: assert property (softResetPulse |=> ##1 !convStart [*4])
    else $error("conversion started after soft reset");
  a_heater_edge: assert property ($changed(heaterOn) |-> !sclIn)
    else $error("heater changed while bus clock high");
  a_drive_edge: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data line driven while bus clock high");
endmodule

bind sensor_config_serial_regs sensor_config_serial_regs_assertions checker_i (
  .clock(clock), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .supplyLowIn(supplyLowIn), .convDone(convDone), .convStart(convStart),
  .convHumidity(convHumidity), .convBits(convBits), .heaterOn(heaterOn),
  .softResetPulse(softResetPulse)
);
`default_nettype wire

// File: verif/tb_sensor_config_serial_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sensor_config_serial_regs;
  localparam logic [6:0] ADDR = 7'h40;
  localparam logic [40:0] ID = 41'h1_5a3c_9e07_b6; // arbitrary unit identifier
  // ==================================================
  // case table
  typedef struct packed {
    logic [15:0] cfg; // value written
    logic [7:0] ptr; // trigger pointer
    logic [15:0] rd; // expected read back
    logic heat; // expected heater
    logic [1:0] n; // conversions expected
    logic [3:0] b0; // first width
    logic [3:0] b1; // second width
  } row_t;
  row_t rows[6] = '{
    '{16'h2000, 8'h00, 16'h2000, 1'h1, 2'h1, 4'he, 4'h0},
    '{16'h0400, 8'h00, 16'h0400, 1'h0, 2'h1, 4'hb, 4'h0},
    '{16'h0100, 8'h01, 16'h0100, 1'h0, 2'h1, 4'hb, 4'h0},
    '{16'h0200, 8'h01, 16'h0200, 1'h0, 2'h1, 4'h8, 4'h0},
    '{16'h1500, 8'h01, 16'h1500, 1'h0, 2'h2, 4'hb, 4'hb},
    '{16'h3a00, 8'h00, 16'h3200, 1'h1, 2'h2, 4'he, 4'h8}
  };
  logic clock, rst_n, supplyLowIn, convDone, sdaOut, sdaOe, convStart, convHumidity;
  logic heaterOn, softResetPulse, ack;
  logic [3:0] convBits;
  logic [7:0] rx;
  wire sclLine, sdaLine;
  int mismatches = 0;
  int samples_checked = 0;
  int doneCnt = 0; // converter busy countdown
  int pulses = 0; // soft reset pulses seen
  logic [4:0] seen[$]; // {humidity, width} per conversion
  sensor_config_serial_regs #(.DEVICE_ADDRESS(ADDR), .UNIT_ID(ID)) dut (
    .clock(clock), .rst_n(rst_n), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .supplyLowIn(supplyLowIn), .convDone(convDone), .convStart(convStart),
    .convHumidity(convHumidity), .convBits(convBits), .heaterOn(heaterOn),
    .softResetPulse(softResetPulse)
  );
  two_wire_host host (.clock(clock), .sdaOe(sdaOe), .sdaOut(sdaOut), .sclLine(sclLine),
    .sdaLine(sdaLine));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // converter: done pulse 12 cycles after each start
  always @(posedge clock)
  begin
    convDone <= (doneCnt == 1);
    if (convStart)
    begin
      seen.push_back({convHumidity, convBits});
      doneCnt <= 12;
    end
    else if (doneCnt != 0)
      doneCnt <= doneCnt - 1;
    if (softResetPulse)
      pulses++;
  end
  // ==================================================
  // helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] v, input logic full);
    host.start();
    host.xfer({ADDR, 1'b0}, 1'b1, rx, ack);
    check(16'(ack), 16'h0000);
    host.xfer(p, 1'b1, rx, ack);
    if (full)
    begin
      host.xfer(v[15:8], 1'b1, rx, ack);
      host.xfer(v[7:0], 1'b1, rx, ack);
    end
    host.stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] v);
    wr(p, 16'h0000, 1'b0);
    host.start();
    host.xfer({ADDR, 1'b1}, 1'b1, rx, ack);
    host.xfer(8'hff, 1'b0, v[15:8], ack);
    host.xfer(8'hff, 1'b1, v[7:0], ack);
    host.stop();
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==================================================
  // main sequence
  initial
  begin
    logic [15:0] v;
    int k;
    rst_n = 1'b0;
    supplyLowIn = 1'b0;
    repeat (6) @(posedge clock);
    #5 rst_n = 1'b1;
    check(16'({sdaOut, heaterOn, convStart, sdaOe, convBits}), 16'h000e);
    host.tick(4);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h02, rows[i].cfg, 1'b1);
      check(16'(heaterOn), 16'(rows[i].heat));
      rd(8'h02, v);
      check(v, rows[i].rd);
      seen.delete();
      wr(rows[i].ptr, 16'h0000, 1'b0);
      k = 0;
      while (seen.size() < rows[i].n && k < 2000)
      begin
        @(posedge clock);
        k++;
      end
      if (k == 2000)
      begin
        // timed out: counted here, the run still ends at the closing report
        mismatches++;
        $display("BAD time=%0t got=%h exp=%h", $time, seen.size(), rows[i].n);
      end
      repeat (40) @(posedge clock);
      check(16'(seen.size()), 16'(rows[i].n));
      check(16'(seen[0]), 16'({rows[i].n == 2'h1 && rows[i].ptr[0], rows[i].b0}));
      if (rows[i].n == 2'h2)
        check(16'(seen[1]), 16'({1'b1, rows[i].b1}));
      $display("row %0d done", i);
    end
    wr(8'hfb, 16'h0000, 1'b1);
    rd(8'hfb, v);
    check(v, ID[40:25]);
    rd(8'hfc, v);
    check(v, ID[24:9]);
    rd(8'h05, v);
    check(v, 16'h0000);
    $display("identifier test done");
    supplyLowIn = 1'b1;
    rd(8'h02, v);
    check(v, 16'h3a00);
    $display("supply test done");
    wr(8'h02, 16'hb400, 1'b1);
    check(16'(pulses), 16'h0001);
    check(16'(heaterOn), 16'h0000);
    rd(8'h02, v);
    check(v, 16'h0800);
    host.start();
    host.xfer({7'h41, 1'b0}, 1'b1, rx, ack);
    host.stop();
    check(16'(ack), 16'h0001);
    $display("reset and address test done");
    // reset in mid-run clears the fields; supply flag follows its pin again
    wr(8'h02, 16'h2000, 1'b1);
    check(16'(heaterOn), 16'h0001);
    rst_n = 1'b0;
    host.tick(2);
    check(16'(heaterOn), 16'h0000);
    rst_n = 1'b1;
    host.tick(4);
    rd(8'h02, v);
    check(v, 16'h0800);
    $display("mid-run reset test done");
    final_report();
  end
endmodule
`default_nettype wire

// File: verif/two_wire_host.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// two-wire bus host, six-cycle clock phases
module two_wire_host (
  input wire logic clock,
  input wire logic sdaOe,
  input wire logic sdaOut,
  output logic sclLine,
  output logic sdaLine
);
  logic sdaHost; // host drive, 1 releases the line
  // open-drain data line with pull-up
  assign sdaLine = sdaHost & (sdaOe ? sdaOut : 1'b1);
  initial
  begin
    sclLine = 1'b1;
    sdaHost = 1'b1;
  end
  // wait n cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  // data falls while the bus clock is high
  task automatic start();
    sdaHost = 1'b1;
    sclLine = 1'b1;
    tick(6);
    sdaHost = 1'b0;
    tick(6);
    sclLine = 1'b0;
  endtask
  // data rises while the bus clock is high; lines then stand idle
  task automatic stop();
    tick(3);
    sdaHost = 1'b0;
    tick(3);
    sclLine = 1'b1;
    tick(6);
    sdaHost = 1'b1;
    tick(6);
  endtask
  // one byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
                      output logic ackIn);
    logic [8:0] bits;
    logic [8:0] got;
    bits = {tx, ackOut};
    for (int i = 8; i >= 0; i--)
    begin
      tick(3);
      sdaHost = bits[i];
      tick(3);
      sclLine = 1'b1;
      tick(3);
      got[i] = sdaLine;
      tick(3);
      sclLine = 1'b0;
    end
    rx = got[8:1];
    ackIn = got[0];
  endtask
endmodule
`default_nettype wire
